// ===== hdl/gdp_pkg.sv
// shared constants and the register state type for the gpio direction / pull-up control block
package gdp_pkg;

    // port widths
    localparam int PORT_A_WIDTH = 32;
    localparam int PORT_B_WIDTH = 32;
    localparam int PORT_C_WIDTH = 24;
    localparam int DATA_WIDTH = 32;
    localparam int DECODE_WIDTH = 8;

    // register byte offsets
    localparam logic [7:0] OFF_DIR_A = 8'h00;
    localparam logic [7:0] OFF_DIR_B = 8'h04;
    localparam logic [7:0] OFF_DIR_C = 8'h08;
    localparam logic [7:0] OFF_PUD_A = 8'h0C;
    localparam logic [7:0] OFF_PUD_B = 8'h10;
    localparam logic [7:0] OFF_PUD_C = 8'h14;
    localparam logic [7:0] OFF_STATUS = 8'h18;
    localparam logic [7:0] OFF_OE_A = 8'h1C;
    localparam logic [7:0] OFF_OE_B = 8'h20;
    localparam logic [7:0] OFF_OE_C = 8'h24;

    // status field positions
    localparam int STATUS_WR_OPEN_BIT = 0;
    localparam int STATUS_REFUSED_BIT = 1;

    // pins that can carry pulse_width_unit outputs: port A pins 0..11
    localparam logic [31:0] PWM_PIN_MASK_A = 32'h0000_0FFF;

    // reset values
    localparam logic [31:0] DIR_RESET = 32'h0000_0000;
    localparam logic [31:0] PUD_A_RESET = PWM_PIN_MASK_A;
    localparam logic [31:0] PUD_B_RESET = 32'h0000_0000;
    localparam logic [23:0] PUD_C_RESET = 24'h00_0000;

    // whole register-file and bus-answer state
    typedef struct packed {
        logic [PORT_A_WIDTH-1:0] dir_a;
        logic [PORT_B_WIDTH-1:0] dir_b;
        logic [PORT_C_WIDTH-1:0] dir_c;
        logic [PORT_A_WIDTH-1:0] pud_a;
        logic [PORT_B_WIDTH-1:0] pud_b;
        logic [PORT_C_WIDTH-1:0] pud_c;
        logic refused;
        logic wr_ok;
        logic wr_deny;
        logic [DATA_WIDTH-1:0] prdata;
        logic pready;
        logic pslverr;
    } gdp_regs_s;

endpackage

// ===== hdl/gdp_pin_stage.sv
// per-port pin driver stage: output enable, output level and pull-up control
`timescale 1ns/10ps

module gdp_pin_stage #(
    parameter int WIDTH = 32,
    parameter logic [31:0] ASYNC_MASK = 32'h0000_0000
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic ext_rst_n,
    input wire logic [WIDTH-1:0] gpio_sel,
    input wire logic [WIDTH-1:0] dir,
    input wire logic [WIDTH-1:0] latch,
    input wire logic [WIDTH-1:0] pud,
    output logic [WIDTH-1:0] pin_out,
    output logic [WIDTH-1:0] pin_oe,
    output logic [WIDTH-1:0] pullup_off
);

    typedef struct packed {
        logic [WIDTH-1:0] out;
        logic [WIDTH-1:0] oe;
        logic [WIDTH-1:0] pud;
    } gdp_stage_s;

    localparam logic [WIDTH-1:0] FORCE = ASYNC_MASK[WIDTH-1:0];
    localparam gdp_stage_s IDLE = '{out: '0, oe: '0, pud: FORCE};

    gdp_stage_s st;
    gdp_stage_s next_st;

    if (WIDTH < 1 || WIDTH > 32) begin : g_bad_width
        $error("gdp_pin_stage: WIDTH must be 1..32");
    end

    always_comb begin
        next_st = st;
        next_st.out = latch;
        // direction only counts for pins muxed to gpio
        next_st.oe = gpio_sel & dir;
        // pull-up follows its register in every mux mode
        next_st.pud = pud;
    end

    // external reset pin acts without the clock; constants only
    always_ff @(posedge clk or negedge ext_rst_n) begin
        if (!ext_rst_n) begin
            st <= IDLE;
        end else if (sys_rst) begin
            st <= IDLE;
        end else begin
            st <= next_st;
        end
    end

    assign pin_out = st.out;
    assign pin_oe = st.oe;
    assign pullup_off = st.pud;

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_live;
        ext_rst_n ##1 ext_rst_n;
    endsequence

    property p_pwm_pullup_off;
        !ext_rst_n |-> (pullup_off & FORCE) == FORCE;
    endproperty
    a_pwm_pullup_off: assert property (p_pwm_pullup_off)
        else $error("pwm-capable pull-ups not off during external reset");

    property p_other_pullup_on;
        !ext_rst_n |-> ((pullup_off & ~FORCE) == '0) && (pin_oe == '0);
    endproperty
    a_other_pullup_on: assert property (p_other_pullup_on)
        else $error("other pull-ups not on during external reset");

    property p_dir_gated;
        s_live |-> pin_oe == ($past(gpio_sel) & $past(dir));
    endproperty
    a_dir_gated: assert property (p_dir_gated)
        else $error("output enable does not follow direction in gpio mode");

    property p_periph_no_oe;
        s_live |-> (pin_oe & ~$past(gpio_sel)) == '0;
    endproperty
    a_periph_no_oe: assert property (p_periph_no_oe)
        else $error("peripheral pin driven by direction bit");

    property p_latch_driven;
        s_live |-> pin_out == $past(latch);
    endproperty
    a_latch_driven: assert property (p_latch_driven)
        else $error("pin level does not follow output latch");

    property p_pullup_any_mode;
        s_live |-> pullup_off == $past(pud);
    endproperty
    a_pullup_any_mode: assert property (p_pullup_any_mode)
        else $error("pull-up output does not follow its register");

endmodule

// ===== hdl/gdp_ctrl.sv
// apb register file and pin control for three gpio ports
`timescale 1ns/10ps

module gdp_ctrl
    import gdp_pkg::*;
#(
    parameter int ADDR_WIDTH = 12
) (
    input wire logic SYS_CLK,
    input wire logic SYS_RST,
    input wire logic EXT_RESET_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [ADDR_WIDTH-1:0] PADDR,
    input wire logic [gdp_pkg::DATA_WIDTH-1:0] PWDATA,
    output logic [gdp_pkg::DATA_WIDTH-1:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic PROTECTED_WRITE_ENABLE,
    input wire logic [gdp_pkg::PORT_A_WIDTH-1:0] PORT_A_GPIO_SEL,
    input wire logic [gdp_pkg::PORT_B_WIDTH-1:0] PORT_B_GPIO_SEL,
    input wire logic [gdp_pkg::PORT_C_WIDTH-1:0] PORT_C_GPIO_SEL,
    input wire logic [gdp_pkg::PORT_A_WIDTH-1:0] PORT_A_DATA_LATCH,
    input wire logic [gdp_pkg::PORT_B_WIDTH-1:0] PORT_B_DATA_LATCH,
    input wire logic [gdp_pkg::PORT_C_WIDTH-1:0] PORT_C_DATA_LATCH,
    output logic [gdp_pkg::PORT_A_WIDTH-1:0] PORT_A_PIN_OUT,
    output logic [gdp_pkg::PORT_B_WIDTH-1:0] PORT_B_PIN_OUT,
    output logic [gdp_pkg::PORT_C_WIDTH-1:0] PORT_C_PIN_OUT,
    output logic [gdp_pkg::PORT_A_WIDTH-1:0] PORT_A_PIN_OE,
    output logic [gdp_pkg::PORT_B_WIDTH-1:0] PORT_B_PIN_OE,
    output logic [gdp_pkg::PORT_C_WIDTH-1:0] PORT_C_PIN_OE,
    output logic [gdp_pkg::PORT_A_WIDTH-1:0] PORT_A_PULLUP_OFF,
    output logic [gdp_pkg::PORT_B_WIDTH-1:0] PORT_B_PULLUP_OFF,
    output logic [gdp_pkg::PORT_C_WIDTH-1:0] PORT_C_PULLUP_OFF
);

    import gdp_pkg::*;

    localparam gdp_regs_s REGS_RESET = '{
        dir_a: DIR_RESET[PORT_A_WIDTH-1:0],
        dir_b: DIR_RESET[PORT_B_WIDTH-1:0],
        dir_c: DIR_RESET[PORT_C_WIDTH-1:0],
        pud_a: PUD_A_RESET,
        pud_b: PUD_B_RESET,
        pud_c: PUD_C_RESET,
        refused: 1'b0,
        wr_ok: 1'b0,
        wr_deny: 1'b0,
        prdata: '0,
        pready: 1'b0,
        pslverr: 1'b0
    };

    gdp_regs_s st;
    gdp_regs_s next_st;

    logic [7:0] offset;
    logic in_range;
    logic setup;
    logic access_done;
    logic hit;
    logic is_protected;
    logic is_read_only;
    logic [DATA_WIDTH-1:0] read_data;

    if (ADDR_WIDTH < DECODE_WIDTH || ADDR_WIDTH > 32) begin : g_bad_addr
        $error("gdp_ctrl: ADDR_WIDTH must be 8..32");
    end

    assign offset = PADDR[DECODE_WIDTH-1:0];
    // aliases above the decoded byte range are refused, not folded
    assign in_range = (PADDR >> DECODE_WIDTH) == '0;
    assign setup = PSEL && !PENABLE;
    assign access_done = PSEL && PENABLE && st.pready;

    // address decode and read mux
    always_comb begin
        hit = in_range;
        is_protected = 1'b0;
        is_read_only = 1'b0;
        read_data = '0;
        unique case (offset)
            OFF_DIR_A: begin
                is_protected = 1'b1;
                read_data = st.dir_a;
            end
            OFF_DIR_B: begin
                is_protected = 1'b1;
                read_data = st.dir_b;
            end
            OFF_DIR_C: begin
                is_protected = 1'b1;
                read_data = {{(DATA_WIDTH - PORT_C_WIDTH){1'b0}}, st.dir_c};
            end
            OFF_PUD_A: begin
                is_protected = 1'b1;
                read_data = st.pud_a;
            end
            OFF_PUD_B: begin
                is_protected = 1'b1;
                read_data = st.pud_b;
            end
            OFF_PUD_C: begin
                is_protected = 1'b1;
                read_data = {{(DATA_WIDTH - PORT_C_WIDTH){1'b0}}, st.pud_c};
            end
            OFF_STATUS: begin
                is_read_only = 1'b1;
                read_data[STATUS_WR_OPEN_BIT] = PROTECTED_WRITE_ENABLE;
                read_data[STATUS_REFUSED_BIT] = st.refused;
            end
            OFF_OE_A: begin
                is_read_only = 1'b1;
                read_data = PORT_A_PIN_OE;
            end
            OFF_OE_B: begin
                is_read_only = 1'b1;
                read_data = PORT_B_PIN_OE;
            end
            OFF_OE_C: begin
                is_read_only = 1'b1;
                read_data = {{(DATA_WIDTH - PORT_C_WIDTH){1'b0}}, PORT_C_PIN_OE};
            end
            default: begin
                hit = 1'b0;
            end
        endcase
        if (!in_range) begin
            hit = 1'b0;
            read_data = '0;
        end
    end

    always_comb begin
        next_st = st;
        next_st.pready = 1'b0;
        next_st.pslverr = 1'b0;

        // answer is prepared in setup so pready leaves a flip-flop
        if (setup) begin
            next_st.pready = 1'b1;
            next_st.prdata = PWRITE ? '0 : read_data;
            // write access sampled once per transfer, at setup
            next_st.wr_ok = PWRITE && hit && is_protected && PROTECTED_WRITE_ENABLE;
            next_st.wr_deny = PWRITE && hit && is_protected && !PROTECTED_WRITE_ENABLE;
            next_st.pslverr = !hit || (PWRITE && (is_read_only || !PROTECTED_WRITE_ENABLE));
        end

        if (access_done) begin
            // reading status clears the refused flag
            if (!PWRITE && hit && offset == OFF_STATUS) begin
                next_st.refused = 1'b0;
            end
            if (st.wr_ok) begin
                unique case (offset)
                    OFF_DIR_A: next_st.dir_a = PWDATA;
                    OFF_DIR_B: next_st.dir_b = PWDATA;
                    OFF_DIR_C: next_st.dir_c = PWDATA[PORT_C_WIDTH-1:0];
                    OFF_PUD_A: next_st.pud_a = PWDATA;
                    OFF_PUD_B: next_st.pud_b = PWDATA;
                    OFF_PUD_C: next_st.pud_c = PWDATA[PORT_C_WIDTH-1:0];
                    default: begin
                    end
                endcase
            end
            // a refusal in the same cycle as the clearing read wins
            if (st.wr_deny) begin
                next_st.refused = 1'b1;
            end
            next_st.wr_ok = 1'b0;
            next_st.wr_deny = 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            st <= REGS_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign PRDATA = st.prdata;
    assign PREADY = st.pready;
    assign PSLVERR = st.pslverr;

    gdp_pin_stage #(
        .WIDTH(PORT_A_WIDTH),
        .ASYNC_MASK(PWM_PIN_MASK_A)
    ) u_port_a (
        .clk(SYS_CLK),
        .sys_rst(SYS_RST),
        .ext_rst_n(EXT_RESET_N),
        .gpio_sel(PORT_A_GPIO_SEL),
        .dir(st.dir_a),
        .latch(PORT_A_DATA_LATCH),
        .pud(st.pud_a),
        .pin_out(PORT_A_PIN_OUT),
        .pin_oe(PORT_A_PIN_OE),
        .pullup_off(PORT_A_PULLUP_OFF)
    );

    gdp_pin_stage #(
        .WIDTH(PORT_B_WIDTH),
        .ASYNC_MASK(32'h0000_0000)
    ) u_port_b (
        .clk(SYS_CLK),
        .sys_rst(SYS_RST),
        .ext_rst_n(EXT_RESET_N),
        .gpio_sel(PORT_B_GPIO_SEL),
        .dir(st.dir_b),
        .latch(PORT_B_DATA_LATCH),
        .pud(st.pud_b),
        .pin_out(PORT_B_PIN_OUT),
        .pin_oe(PORT_B_PIN_OE),
        .pullup_off(PORT_B_PULLUP_OFF)
    );

    gdp_pin_stage #(
        .WIDTH(PORT_C_WIDTH),
        .ASYNC_MASK(32'h0000_0000)
    ) u_port_c (
        .clk(SYS_CLK),
        .sys_rst(SYS_RST),
        .ext_rst_n(EXT_RESET_N),
        .gpio_sel(PORT_C_GPIO_SEL),
        .dir(st.dir_c),
        .latch(PORT_C_DATA_LATCH),
        .pud(st.pud_c),
        .pin_out(PORT_C_PIN_OUT),
        .pin_oe(PORT_C_PIN_OE),
        .pullup_off(PORT_C_PULLUP_OFF)
    );

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (SYS_RST);

    sequence s_rd_setup(logic [7:0] off);
        PSEL && !PENABLE && !PWRITE && in_range && offset == off;
    endsequence

    sequence s_wr_done(logic [7:0] off);
        PSEL && PENABLE && PREADY && PWRITE && in_range && offset == off;
    endsequence

    property p_dir_reset;
        $past(SYS_RST) |-> st.dir_a == '0 && st.dir_b == '0 && st.dir_c == '0;
    endproperty
    a_dir_reset: assert property (p_dir_reset)
        else $error("direction registers not cleared by reset");

    property p_pud_a_reset;
        $past(SYS_RST) |-> st.pud_a == PUD_A_RESET && st.pud_b == '0;
    endproperty
    a_pud_a_reset: assert property (p_pud_a_reset)
        else $error("pull-up disable reset value wrong");

    property p_locked_write;
        (s_wr_done(OFF_DIR_A) ##0 !st.wr_ok) |=> $stable(st.dir_a) ##0 st.refused;
    endproperty
    a_locked_write: assert property (p_locked_write)
        else $error("direction written while write access closed");

    property p_dir_readback;
        s_rd_setup(OFF_DIR_B) |=> PREADY && PRDATA == $past(st.dir_b);
    endproperty
    a_dir_readback: assert property (p_dir_readback)
        else $error("direction read does not return stored setting");

    property p_dir_c_reserved;
        s_rd_setup(OFF_DIR_C) |=> PRDATA[31:24] == 8'h00 ##1 !PREADY;
    endproperty
    a_dir_c_reserved: assert property (p_dir_c_reserved)
        else $error("port C reserved direction bits not zero");

    property p_pud_hold;
        !(PSEL && PENABLE && PREADY && PWRITE && st.wr_ok) |=> $stable(st.pud_a);
    endproperty
    a_pud_hold: assert property (p_pud_hold)
        else $error("pull-up setting changed without a write");

    property p_pud_bit_map;
        (EXT_RESET_N ##1 EXT_RESET_N) |-> PORT_A_PULLUP_OFF == $past(st.pud_a);
    endproperty
    a_pud_bit_map: assert property (p_pud_bit_map)
        else $error("pull-up bit does not map to its pin");

endmodule

// ===== dv/gdp_ctrl_tb.sv
// self-checking bench for the gpio direction and pull-up control block
`timescale 1ns/10ps

module gdp_ctrl_tb;
    import gdp_pkg::*;

    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic ext_rst_n = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic pwe = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [31:0] sel_a = 32'h0, sel_b = 32'h0, lat_a = 32'h0, lat_b = 32'h0;
    logic [23:0] sel_c = 24'h0, lat_c = 24'h0;
    logic [31:0] out_a, out_b, oe_a, oe_b, pu_a, pu_b;
    logic [23:0] out_c, oe_c, pu_c;
    // expected answers: {is_read, pslverr, prdata}
    logic [33:0] exp_q[$];
    int num_errors = 0;
    int checks_done = 0;
    // register image kept by the bench
    logic [31:0] dir_a = 32'h0, dir_b = 32'h0, pud_a = 32'h0, pud_b = 32'h0;
    logic [23:0] dir_c = 24'h0, pud_c = 24'h0;

    gdp_ctrl #(.ADDR_WIDTH(12)) uut (
        .SYS_CLK(sys_clk),
        .SYS_RST(sys_rst),
        .EXT_RESET_N(ext_rst_n),
        .PSEL(psel),
        .PENABLE(penable),
        .PWRITE(pwrite),
        .PADDR(paddr),
        .PWDATA(pwdata),
        .PRDATA(prdata),
        .PREADY(pready),
        .PSLVERR(pslverr),
        .PROTECTED_WRITE_ENABLE(pwe),
        .PORT_A_GPIO_SEL(sel_a),
        .PORT_B_GPIO_SEL(sel_b),
        .PORT_C_GPIO_SEL(sel_c),
        .PORT_A_DATA_LATCH(lat_a),
        .PORT_B_DATA_LATCH(lat_b),
        .PORT_C_DATA_LATCH(lat_c),
        .PORT_A_PIN_OUT(out_a),
        .PORT_B_PIN_OUT(out_b),
        .PORT_C_PIN_OUT(out_c),
        .PORT_A_PIN_OE(oe_a),
        .PORT_B_PIN_OE(oe_b),
        .PORT_C_PIN_OE(oe_c),
        .PORT_A_PULLUP_OFF(pu_a),
        .PORT_B_PULLUP_OFF(pu_b),
        .PORT_C_PULLUP_OFF(pu_c)
    );

    initial begin
        forever #25 sys_clk = ~sys_clk;
    end

    task automatic stop_test();
        $display("checks_done %0d num_errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one apb transfer; leaves psel high so a setup may follow at once
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd,
                       input logic [31:0] exp, input logic err);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        exp_q.push_back({~wr, err, exp});
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            num_errors++;
            $display("[FAIL] pready expected 1 seen %b", pready);
            stop_test();
        end
        penable <= 1'b0;
    endtask

    task automatic idle();
        psel <= 1'b0;
        @(posedge sys_clk);
    endtask

    // pin stage lags its inputs by one clock; look at the falling edge
    task automatic check_pins();
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        chk("oe_a", sel_a & dir_a, oe_a);
        chk("oe_b", sel_b & dir_b, oe_b);
        chk("oe_c", {8'h0, sel_c & dir_c}, {8'h0, oe_c});
        chk("out_a", lat_a, out_a);
        chk("out_b", lat_b, out_b);
        chk("out_c", {8'h0, lat_c}, {8'h0, out_c});
        chk("pu_a", pud_a, pu_a);
        chk("pu_b", pud_b, pu_b);
        chk("pu_c", {8'h0, pud_c}, {8'h0, pu_c});
        @(posedge sys_clk);
    endtask

    // scoreboard: every answered transfer takes the oldest note
    always @(posedge sys_clk) begin
        logic [33:0] e;
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
            if (exp_q.size() == 0) begin
                num_errors++;
                $display("[FAIL] apb answer expected none seen one");
            end else begin
                e = exp_q.pop_front();
                chk("pslverr", {31'h0, e[32]}, {31'h0, pslverr});
                if (e[33]) begin
                    chk("prdata", e[31:0], prdata);
                end
            end
        end
    end

    initial begin
        #(50 * 20000);
        num_errors++;
        $display("[FAIL] run time expected below limit seen limit");
        stop_test();
    end

    initial begin
        void'($urandom(32'h60d2));
        repeat (10) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        pud_a = PUD_A_RESET;
        apb(1'b0, {4'h0, OFF_DIR_A}, 32'h0, DIR_RESET, 1'b0);
        apb(1'b0, {4'h0, OFF_DIR_B}, 32'h0, DIR_RESET, 1'b0);
        apb(1'b0, {4'h0, OFF_DIR_C}, 32'h0, DIR_RESET, 1'b0);
        apb(1'b0, {4'h0, OFF_PUD_A}, 32'h0, PUD_A_RESET, 1'b0);
        apb(1'b0, {4'h0, OFF_PUD_B}, 32'h0, 32'h0, 1'b0);
        apb(1'b0, {4'h0, OFF_PUD_C}, 32'h0, 32'h0, 1'b0);
        idle();
        check_pins();
        // writes with the protection gate closed must bounce
        apb(1'b1, {4'h0, OFF_DIR_A}, 32'hFFFF_FFFF, 32'h0, 1'b1);
        apb(1'b1, {4'h0, OFF_PUD_A}, 32'h0, 32'h0, 1'b1);
        apb(1'b0, {4'h0, OFF_DIR_A}, 32'h0, 32'h0, 1'b0);
        apb(1'b0, {4'h0, OFF_PUD_A}, 32'h0, PUD_A_RESET, 1'b0);
        apb(1'b0, {4'h0, OFF_STATUS}, 32'h0, 32'h2, 1'b0);
        apb(1'b0, {4'h0, OFF_STATUS}, 32'h0, 32'h0, 1'b0);
        apb(1'b0, 12'h02C, 32'h0, 32'h0, 1'b1);
        apb(1'b1, 12'h100, 32'h1234_5678, 32'h0, 1'b1);
        idle();
        pwe <= 1'b1;
        @(posedge sys_clk);
        // first pass all pins gpio, second all peripheral, then random mixes
        for (int i = 0; i < 5; i++) begin
            sel_a <= (i == 0) ? 32'hFFFF_FFFF : (i == 1) ? 32'h0 : $urandom;
            sel_b <= (i == 0) ? 32'hFFFF_FFFF : (i == 1) ? 32'h0 : $urandom;
            sel_c <= (i == 0) ? 24'hFF_FFFF : (i == 1) ? 24'h0 : 24'($urandom);
            // latch preset ahead of the direction writes
            lat_a <= $urandom;
            lat_b <= $urandom;
            lat_c <= 24'($urandom);
            dir_a = $urandom;
            dir_b = $urandom;
            dir_c = 24'($urandom);
            pud_a = $urandom;
            pud_b = $urandom;
            pud_c = 24'($urandom);
            apb(1'b1, {4'h0, OFF_DIR_A}, dir_a, 32'h0, 1'b0);
            apb(1'b1, {4'h0, OFF_DIR_B}, dir_b, 32'h0, 1'b0);
            apb(1'b1, {4'h0, OFF_DIR_C}, {8'hFF, dir_c}, 32'h0, 1'b0);
            apb(1'b1, {4'h0, OFF_PUD_A}, pud_a, 32'h0, 1'b0);
            apb(1'b1, {4'h0, OFF_PUD_B}, pud_b, 32'h0, 1'b0);
            apb(1'b1, {4'h0, OFF_PUD_C}, {8'h00, pud_c}, 32'h0, 1'b0);
            apb(1'b0, {4'h0, OFF_DIR_A}, 32'h0, dir_a, 1'b0);
            apb(1'b0, {4'h0, OFF_DIR_B}, 32'h0, dir_b, 1'b0);
            apb(1'b0, {4'h0, OFF_DIR_C}, 32'h0, {8'h0, dir_c}, 1'b0);
            apb(1'b0, {4'h0, OFF_PUD_A}, 32'h0, pud_a, 1'b0);
            apb(1'b0, {4'h0, OFF_STATUS}, 32'h0, 32'h1, 1'b0);
            idle();
            check_pins();
            apb(1'b0, {4'h0, OFF_PUD_B}, 32'h0, pud_b, 1'b0);
            apb(1'b0, {4'h0, OFF_PUD_C}, 32'h0, {8'h0, pud_c}, 1'b0);
            // read-only enables refuse a write even with the gate open
            apb(1'b1, {4'h0, OFF_OE_A}, 32'hFFFF_FFFF, 32'h0, 1'b1);
            apb(1'b0, {4'h0, OFF_OE_A}, 32'h0, sel_a & dir_a, 1'b0);
            apb(1'b0, {4'h0, OFF_OE_B}, 32'h0, sel_b & dir_b, 1'b0);
            apb(1'b0, {4'h0, OFF_OE_C}, 32'h0, {8'h0, sel_c & dir_c}, 1'b0);
            idle();
        end
        pud_a = 32'h0;
        apb(1'b1, {4'h0, OFF_PUD_A}, pud_a, 32'h0, 1'b0);
        idle();
        check_pins();
        // reset pin must act before any clock edge arrives
        // pin alone for one edge so the pin-stage reset checks are armed
        ext_rst_n <= 1'b0;
        #5;
        chk("pu_a in reset", PWM_PIN_MASK_A, pu_a);
        chk("pu_b in reset", 32'h0, pu_b);
        chk("pu_c in reset", 32'h0, {8'h0, pu_c});
        chk("oe_a in reset", 32'h0, oe_a);
        chk("out_a in reset", 32'h0, out_a);
        @(posedge sys_clk);
        sys_rst <= 1'b1;
        repeat (10) @(posedge sys_clk);
        ext_rst_n <= 1'b1;
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        dir_a = 32'h0;
        dir_b = 32'h0;
        dir_c = 24'h0;
        pud_a = PUD_A_RESET;
        pud_b = 32'h0;
        pud_c = 24'h0;
        apb(1'b0, {4'h0, OFF_PUD_A}, 32'h0, PUD_A_RESET, 1'b0);
        apb(1'b0, {4'h0, OFF_DIR_C}, 32'h0, 32'h0, 1'b0);
        idle();
        check_pins();
        stop_test();
    end
endmodule
